/* File: rtl/ebc_seq.sv */
// ebc_seq: external bus cycle sequencer with avalon-mm register slave
// Behaviour
// - every external cycle walks address setup, command delay and write setup if nonzero, access, then hold if nonzero.
// - each phase length comes from the timing word of the selected chip select.
// - with ready enabled the access phase stays open until ready allows its end.
// - address setup lasts 1 or 2 units plus 0 to 3 more on a window change, at most 5.
// - command delay runs 0 to 3 units and write setup or tristate 0 to 1 unit.
// - access runs 1 to 32 units, which alone sets its length without ready.
// - in write cycles, address and write data are held 0 to 3 units after the strobe ends.
// - read data are taken on the edge that lifts the read strobe and moves the address.
// - early address changes in demultiplexed reads do not touch the captured data.
// - multiplexed mode puts address, then write data, on the shared 16-bit lines.
// - demultiplexed mode drives a 24-bit address and write data on the data lines.
// - ready sampled inactive adds a wait state, sampled active ends the access phase.
// - asynchronous ready passes an extra stage and costs at least one more wait state.
// - software picks the active level of the ready input.
// assumes an avalon-mm master on clk_i and an external device on the pin groups
`timescale 1ns/10ps
`default_nettype none
module ebc_seq
	import ebc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// external bus outputs
	output ebc_pins_s pins_o,
	// external bus inputs
	input wire logic [DATA_W-1:0] shared_addr_data_bus_i,
	input wire logic [DATA_W-1:0] data_bus_i,
	input wire logic ready_i
);
	// register hit decode, shared by read and write paths
	function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	// phase length in units for a given phase
	function automatic logic [5:0] phase_len(input ebc_state_e ph, input ebc_timing_s t,
			input logic win);
		phase_len = 6'h00;
		case (ph)
			ST_ADDR: phase_len = 6'(t.ab) + 6'h01 + (win ? 6'(t.abext) : 6'h00);
			ST_CMD: phase_len = 6'(t.cmd);
			ST_WSET: phase_len = 6'(t.wset);
			ST_ACC: phase_len = 6'(t.acc) + 6'h01;
			ST_HOLD: phase_len = 6'(t.hold);
			default: phase_len = 6'h00;
		endcase
	endfunction : phase_len

	// next phase, skipping those programmed to zero
	function automatic ebc_state_e next_phase(input ebc_state_e ph, input ebc_timing_s t);
		next_phase = ST_IDLE;
		case (ph)
			ST_ADDR: next_phase = (t.cmd != 2'h0) ? ST_CMD : (t.wset ? ST_WSET : ST_ACC);
			ST_CMD: next_phase = t.wset ? ST_WSET : ST_ACC;
			ST_WSET: next_phase = ST_ACC;
			ST_ACC: next_phase = (t.hold != 2'h0) ? ST_HOLD : ST_IDLE;
			default: next_phase = ST_IDLE;
		endcase
	endfunction : next_phase

	logic [TIM_W-1:0] tim_q [NUM_CS];
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic [CS_W-1:0] cs_sel_q;
	logic wr_sel_q;
	logic bhe_q;
	logic done_q;
	logic ack_q;
	ebc_state_e state_q;
	ebc_state_e state_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	ebc_timing_s cur_q;
	ebc_timing_s sel_t;
	logic [CS_W-1:0] cyc_cs_q;
	logic [CS_W-1:0] last_cs_q;
	logic cyc_wr_q;
	logic [ADDR_W-1:0] pin_addr_q;
	logic win_chg;
	logic start_go;
	logic [CS_W-1:0] go_cs;
	logic rdy_sync;
	logic rdy_late;
	logic rdy_act;
	logic acc_end;
	logic bus_wr;
	logic bus_rd;
	logic busy;

	// avalon request decode; a write commits on the edge where waitrequest is low
	assign bus_wr = avs_write_i && ack_q;
	assign bus_rd = avs_read_i && !ack_q;
	assign busy = (state_q != ST_IDLE);
	// the start write carries the chip select of its own cycle
	assign go_cs = avs_writedata_i[CTRL_CS_LO +: CS_W];
	assign sel_t = ebc_timing_s'(tim_q[go_cs]);
	assign win_chg = (go_cs != last_cs_q);
	assign start_go = bus_wr && reg_hit(avs_address_i, REG_CTRL)
		&& avs_writedata_i[CTRL_START] && !busy;

	// one wait cycle, answer on the second edge
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_i || avs_write_i) && !ack_q;
		end
	end
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

	// read data mux, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (bus_rd) begin
			avs_readdata_o <= 32'h0;
			if (reg_hit(avs_address_i, REG_CTRL)) begin
				avs_readdata_o[CTRL_WRITE] <= wr_sel_q;
				avs_readdata_o[CTRL_CS_LO +: CS_W] <= cs_sel_q;
				avs_readdata_o[CTRL_BHE] <= bhe_q;
				avs_readdata_o[CTRL_BUSY] <= busy;
				avs_readdata_o[CTRL_DONE] <= done_q;
			end else if (reg_hit(avs_address_i, REG_ADDR)) begin
				avs_readdata_o[ADDR_W-1:0] <= addr_q;
			end else if (reg_hit(avs_address_i, REG_WDATA)) begin
				avs_readdata_o[DATA_W-1:0] <= wdata_q;
			end else if (reg_hit(avs_address_i, REG_RDATA)) begin
				avs_readdata_o[DATA_W-1:0] <= rdata_q;
			end else begin
				for (int i = 0; i < NUM_CS; i++) begin
					if (reg_hit(avs_address_i, REG_TIM0 + 5'(4 * i))) begin
						avs_readdata_o[TIM_W-1:0] <= tim_q[i];
					end
				end
			end
		end
	end

	// control, address and write data registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_sel_q <= 1'b0;
			cs_sel_q <= '0;
			bhe_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (bus_wr) begin
			if (reg_hit(avs_address_i, REG_CTRL) && !busy) begin
				wr_sel_q <= avs_writedata_i[CTRL_WRITE];
				cs_sel_q <= avs_writedata_i[CTRL_CS_LO +: CS_W];
				bhe_q <= avs_writedata_i[CTRL_BHE];
			end
			if (reg_hit(avs_address_i, REG_ADDR) && !busy) begin
				addr_q <= avs_writedata_i[ADDR_W-1:0];
			end
			if (reg_hit(avs_address_i, REG_WDATA) && !busy) begin
				wdata_q <= avs_writedata_i[DATA_W-1:0];
			end
		end
	end

	// timing word per chip select
	generate
		for (genvar g = 0; g < NUM_CS; g++) begin : g_tim
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					tim_q[g] <= TIM_RST;
				end else if (bus_wr && reg_hit(avs_address_i, REG_TIM0 + 5'(4 * g))) begin
					tim_q[g] <= avs_writedata_i[TIM_W-1:0];
				end
			end
		end
	endgenerate

	// done flag: end of cycle sets, writing one clears, set wins
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			done_q <= 1'b0;
		end else if (acc_end && next_phase(ST_ACC, cur_q) == ST_IDLE) begin
			done_q <= 1'b1;
		end else if (state_q == ST_HOLD && cnt_q == 6'h00) begin
			done_q <= 1'b1;
		end else if (bus_wr && reg_hit(avs_address_i, REG_CTRL)
				&& avs_writedata_i[CTRL_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// ready pin synchroniser
	ebc_ready_sync u_rdy (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ready_i(ready_i),
		.sync_o(rdy_sync),
		.late_o(rdy_late)
	);
	// pick stage and level
	assign rdy_act = (cur_q.rdy_async ? rdy_late : rdy_sync) == cur_q.rdy_pol;
	assign acc_end = (state_q == ST_ACC) && (cnt_q == 6'h00)
		&& (!cur_q.rdy_en || rdy_act);

	// phase sequencer, counts in whole clocks
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (state_q == ST_IDLE) begin
			if (start_go) begin
				state_d = ST_ADDR;
				cnt_d = 6'(phase_len(ST_ADDR, sel_t, win_chg) - 6'h01);
			end
		end else if (cnt_q != 6'h00) begin
			cnt_d = cnt_q - 6'h01;
		end else if (state_q == ST_ACC && !acc_end) begin
			state_d = ST_ACC;
		end else begin
			state_d = next_phase(state_q, cur_q);
			cnt_d = 6'(phase_len(state_d, cur_q, 1'b0) - 6'h01);
		end
	end

	// state, counter and cycle snapshot
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 6'h00;
			cur_q <= ebc_timing_s'(TIM_RST);
			cyc_cs_q <= '0;
			last_cs_q <= '0;
			cyc_wr_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (start_go) begin
				cur_q <= sel_t;
				cyc_cs_q <= go_cs;
				last_cs_q <= go_cs;
				cyc_wr_q <= avs_writedata_i[CTRL_WRITE];
			end
		end
	end

	// read capture on the edge that lifts the read strobe
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_q <= '0;
		end else if (acc_end && !cyc_wr_q) begin
			rdata_q <= cur_q.mux ? shared_addr_data_bus_i : data_bus_i;
		end
	end

	// address pins: loaded at start, moved on the read capture edge
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pin_addr_q <= '0;
		end else if (start_go) begin
			pin_addr_q <= addr_q;
		end else if (acc_end && !cyc_wr_q) begin
			pin_addr_q <= '0;
		end
	end

	// pin decode from phase
	always_comb begin
		pins_o.addr = pin_addr_q;
		pins_o.ale = cur_q.mux && state_q == ST_ADDR;
		pins_o.ad = (state_q == ST_ADDR || state_q == ST_CMD) ? pin_addr_q[DATA_W-1:0] : wdata_q;
		pins_o.ad_oe = cur_q.mux && (state_q == ST_ADDR || state_q == ST_CMD
			|| (cyc_wr_q && state_q inside {ST_WSET, ST_ACC, ST_HOLD}));
		pins_o.d = wdata_q;
		pins_o.d_oe = !cur_q.mux && cyc_wr_q
			&& state_q inside {ST_WSET, ST_ACC, ST_HOLD};
		pins_o.rd_n = !(state_q == ST_ACC && !cyc_wr_q);
		pins_o.wr_n = !(state_q == ST_ACC && cyc_wr_q);
		pins_o.bhe_n = !(busy && bhe_q);
		pins_o.cs_n = '1;
		if (busy) begin
			pins_o.cs_n[cyc_cs_q] = 1'b0;
		end
	end

	// helper: cycles spent in the current phase and its expected length
	logic [5:0] ph_cyc_q;
	logic [5:0] ph_len_q;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ph_cyc_q <= 6'h00;
			ph_len_q <= 6'h00;
		end else if (state_d != state_q || state_q == ST_IDLE) begin
			ph_cyc_q <= 6'h00;
			ph_len_q <= cnt_d + 6'h01;
		end else begin
			ph_cyc_q <= ph_cyc_q + 6'h01;
		end
	end

	// checks
	phase_order_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_q == ST_ADDR |=> state_q inside {ST_ADDR, ST_CMD, ST_WSET, ST_ACC})
		else $error("address phase left to a wrong phase");
	phase_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q != ST_IDLE && state_q != ST_ACC && state_d != state_q)
		|-> ph_cyc_q + 6'h01 == ph_len_q)
		else $error("phase length differs from programmed count");
	addr_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_q == ST_ADDR |-> ph_len_q <= AB_MAX && ph_len_q != 6'h00)
		else $error("address setup outside 1 to 5 units");
	acc_min_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == ST_ACC && state_d != ST_ACC)
		|-> ph_cyc_q + 6'h01 >= 6'(cur_q.acc) + 6'h01 && ph_cyc_q < ACC_MAX + 6'h01
		|| cur_q.rdy_en)
		else $error("access shorter than programmed");
	ready_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == ST_ACC && cnt_q == 6'h00 && cur_q.rdy_en && !rdy_act) |=> state_q == ST_ACC)
		else $error("access ended without ready");
	ready_end_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		acc_end |=> state_q != ST_ACC && pins_o.rd_n && pins_o.wr_n)
		else $error("access held after ready");
	read_cap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(acc_end && !cyc_wr_q && !cur_q.mux) |=> rdata_q == $past(data_bus_i) && pins_o.rd_n)
		else $error("read data not taken at strobe rise");
	mux_tris_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(cur_q.mux && !cyc_wr_q && state_q inside {ST_WSET, ST_ACC}) |-> !pins_o.ad_oe)
		else $error("shared lines driven during read");
	demux_wr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!cur_q.mux && !pins_o.wr_n) |-> pins_o.d_oe && pins_o.d == wdata_q && !pins_o.ad_oe)
		else $error("write data missing on data lines");
	strobe_acc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!pins_o.rd_n |-> state_q == ST_ACC && pins_o.cs_n != '1)
		else $error("read strobe outside access");
	read_done_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		acc_end && !cyc_wr_q);
	mux_write_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		acc_end && cyc_wr_q && cur_q.mux);
	ready_wait_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
		state_q == ST_ACC && cnt_q == 6'h00 && cur_q.rdy_en && !rdy_act);
endmodule : ebc_seq
`default_nettype wire

/* File: rtl/ebc_pkg.sv */
// ebc_pkg: constants and types of the external bus cycle sequencer
// assumes a single 10 MHz system clock; one phase unit equals one clock
package ebc_pkg;
	// clock and phase unit
	localparam int CLK_PERIOD_NS = 100;
	localparam int PHASE_UNIT_NS = 100;
	localparam int PHASE_UNIT_CYC = (PHASE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte offsets on the avalon slave
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0C;
	localparam logic [4:0] REG_TIM0 = 5'h10;
	localparam int NUM_CS = 4;
	localparam int CS_W = 2;

	// control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_CS_LO = 2;
	localparam int CTRL_BHE = 4;
	localparam int CTRL_BUSY = 8;
	localparam int CTRL_DONE = 9;

	// widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int TIM_W = 17;
	localparam logic [TIM_W-1:0] TIM_RST = 17'h1FFF;
	localparam logic [5:0] AB_MAX = 6'h05;
	localparam logic [5:0] ACC_MAX = 6'h20;

	// per chip select timing word, lsb first: ab, abext, cmd, wset, acc, hold, ready
	typedef struct packed {
		logic mux;
		logic rdy_pol;
		logic rdy_async;
		logic rdy_en;
		logic [1:0] hold;
		logic [4:0] acc;
		logic wset;
		logic [1:0] cmd;
		logic [1:0] abext;
		logic ab;
	} ebc_timing_s;

	// cycle phases
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WSET,
		ST_ACC,
		ST_HOLD
	} ebc_state_e;

	// external pin outputs
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] ad;
		logic ad_oe;
		logic [DATA_W-1:0] d;
		logic d_oe;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic bhe_n;
		logic [NUM_CS-1:0] cs_n;
	} ebc_pins_s;
endpackage : ebc_pkg

/* File: rtl/ebc_ready_sync.sv */
// ebc_ready_sync: three-stage synchroniser for the ready pin
// assumes ready_i is asynchronous to clk_i; gives a filtered level and a one-stage-later copy
`timescale 1ns/10ps
`default_nettype none
module ebc_ready_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// pin and results
	input wire logic ready_i,
	output logic sync_o,
	output logic late_o
);
	logic [2:0] st_q;
	logic filt_q;

	// shift chain; only stage 2 reads stage 1
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_q <= 3'h0;
		end else begin
			st_q <= {st_q[1:0], ready_i};
		end
	end

	// level changes once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			filt_q <= 1'b0;
			late_o <= 1'b0;
		end else begin
			if (st_q[1] == st_q[2]) begin
				filt_q <= st_q[2];
			end
			late_o <= filt_q; // extra stage for asynchronous mode
		end
	end

	assign sync_o = filt_q;
endmodule : ebc_ready_sync
`default_nettype wire

/* File: tb/ebc_mem_model.sv */
// ebc_mem_model: behavioural external memory on the sequencer pins
// assumes the pin struct of ebc_pkg and the sequencer's clock
`timescale 1ns/10ps
`default_nettype none
module ebc_mem_model
	import ebc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// sequencer pins and ready setup
	input wire ebc_pins_s pins_i,
	input wire logic [3:0] rdy_wait_i,
	input wire logic rdy_pol_i,
	// answers
	output logic [DATA_W-1:0] ad_o,
	output logic [DATA_W-1:0] d_o,
	output logic ready_o,
	// last write seen
	output logic [ADDR_W-1:0] wr_addr_o,
	output logic [DATA_W-1:0] wr_data_o,
	output logic wr_bhe_n_o
);
	logic mux_q;
	logic [DATA_W-1:0] lat_q;
	logic [DATA_W-1:0] last_q;
	logic [3:0] wait_q;
	logic strobe;
	logic [ADDR_W-1:0] key;
	logic [DATA_W-1:0] rdat;

	// read data follow the address while the read strobe is low; scrambled once the read strobe is lifted
	assign strobe = !pins_i.rd_n || !pins_i.wr_n;
	assign key = mux_q ? {8'h00, lat_q} : pins_i.addr;
	assign rdat = key[15:0] ^ 16'h5A3C;
	assign ad_o = pins_i.rd_n ? ~last_q : rdat;
	assign d_o = ad_o;
	// ready turns active after the wait and drops with the strobe
	assign ready_o = (strobe && wait_q >= rdy_wait_i) ? rdy_pol_i : !rdy_pol_i;

	// address latch, wait counter and write capture
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mux_q <= 1'b0;
			lat_q <= '0;
			last_q <= '0;
			wait_q <= 4'h0;
		end else begin
			if (pins_i.ale) begin
				mux_q <= 1'b1;
				lat_q <= pins_i.ad;
			end else if (&pins_i.cs_n) begin
				mux_q <= 1'b0;
			end
			if (!pins_i.rd_n) begin
				last_q <= rdat;
			end
			wait_q <= !strobe ? 4'h0 : (wait_q == 4'hF) ? wait_q : wait_q + 4'h1;
			if (!pins_i.wr_n) begin
				wr_addr_o <= key;
				wr_data_o <= mux_q ? pins_i.ad : pins_i.d;
				wr_bhe_n_o <= pins_i.bhe_n;
			end
		end
	end
endmodule : ebc_mem_model
`default_nettype wire

/* File: tb/ebc_seq_test.sv */
// ebc_seq_test: self-checking bench for the bus cycle sequencer
// assumes ebc_mem_model as far side and an avalon master made of tasks
`timescale 1ns/10ps
`default_nettype none
module ebc_seq_test
	import ebc_pkg::*;
;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = '0;
	logic [31:0] rdat;
	logic wreq;
	ebc_pins_s pins;
	logic [DATA_W-1:0] m_ad;
	logic [DATA_W-1:0] m_d;
	logic [DATA_W-1:0] ad_w;
	logic [DATA_W-1:0] d_w;
	logic rdy;
	logic [3:0] rwait = 4'hF;
	logic rpol = 1'b1;
	logic [ADDR_W-1:0] w_adr;
	logic [DATA_W-1:0] w_dat;
	logic w_bhe_n;
	int cs_cnt = 0;
	int st_cnt = 0;
	int al_cnt = 0;
	int mismatches = 0;
	int tests_run = 0;

	always #50 clk_i = ~clk_i;
	// wire levels from both drivers
	assign ad_w = pins.ad_oe ? pins.ad : m_ad;
	assign d_w = pins.d_oe ? pins.d : m_d;

	ebc_seq dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .pins_o(pins), .shared_addr_data_bus_i(ad_w),
		.data_bus_i(d_w), .ready_i(rdy));
	ebc_mem_model mem (.clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins), .rdy_wait_i(rwait),
		.rdy_pol_i(rpol), .ad_o(m_ad), .d_o(m_d), .ready_o(rdy), .wr_addr_o(w_adr),
		.wr_data_o(w_dat), .wr_bhe_n_o(w_bhe_n));

	// cycles with chip select, strobe and address latch active
	always @(posedge clk_i) begin
		cs_cnt <= cs_cnt + ((pins.cs_n != 4'hF) ? 1 : 0);
		st_cnt <= st_cnt + ((!pins.rd_n || !pins.wr_n) ? 1 : 0);
		al_cnt <= al_cnt + (pins.ale ? 1 : 0);
	end

	task automatic stop_test();
		$display("counts: %0d mismatches, %0d tests", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk_i);
		adr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk_i iff wreq === 1'b0);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
		@(posedge clk_i);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk_i iff wreq === 1'b0);
		v = rdat;
		rd <= 1'b0;
	endtask : bus_rd

	// timing word: flags {mux, pol, async, en}, hold, acc, wset, cmd, abext, ab
	task automatic tim(input logic [1:0] cs, input logic [3:0] f, input logic [1:0] h,
		input logic [4:0] acc, input logic ws, input logic [1:0] c, input logic [1:0] x,
		input logic ab);
		bus_wr(5'(REG_TIM0 + {cs, 2'b00}), {15'h0000, f, h, acc, ws, c, x, ab});
	endtask : tim

	task automatic run(input logic [1:0] cs, input logic w, input logic [23:0] a,
		input logic [15:0] d, output int dc, output int ds, output int dl);
		int c0;
		int s0;
		int l0;
		int n;
		logic [31:0] v;
		bus_wr(REG_ADDR, {8'h00, a});
		bus_wr(REG_WDATA, {16'h0000, d});
		c0 = cs_cnt;
		s0 = st_cnt;
		l0 = al_cnt;
		bus_wr(REG_CTRL, {27'h0000000, 1'b1, cs, w, 1'b1});
		n = 0;
		v = '0;
		while (v[CTRL_DONE] !== 1'b1 && n < 200) begin
			bus_rd(REG_CTRL, v);
			n++;
		end
		dc = cs_cnt - c0;
		ds = st_cnt - s0;
		dl = al_cnt - l0;
		check({31'h0, v[CTRL_BUSY]}, 32'h0);
		bus_wr(REG_CTRL, 32'h00000200);
	endtask : run

	// reset values and an unmapped place
	task automatic t_reset();
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			bus_rd(5'(REG_TIM0 + 4 * i), v);
			check(v, {15'h0000, TIM_RST});
		end
		bus_rd(REG_CTRL, v);
		check(v, 32'h0);
		bus_rd(5'h02, v);
		check(v, 32'h0);
	endtask : t_reset

	// demux reads over a table of phase lengths
	task automatic t_phases();
		int ab[4] = '{0, 1, 0, 1};
		int cm[4] = '{0, 3, 2, 1};
		int ws[4] = '{0, 1, 0, 1};
		int ac[4] = '{0, 31, 5, 0};
		int hd[4] = '{0, 3, 1, 2};
		int dc;
		int ds;
		int dl;
		logic [23:0] a;
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			tim(2'd0, 4'h0, 2'(hd[i]), 5'(ac[i]), 1'(ws[i]), 2'(cm[i]), 2'd3, 1'(ab[i]));
			a = 24'h3C0000 + 24'(i * 16'h1357);
			run(2'd0, 1'b0, a, 16'h0000, dc, ds, dl);
			check(32'(dc), 32'(ab[i] + 1 + cm[i] + ws[i] + ac[i] + 1 + hd[i]));
			check(32'(ds), 32'(ac[i] + 1));
			bus_rd(REG_RDATA, v);
			check(v, {16'h0000, a[15:0] ^ 16'h5A3C});
		end
	endtask : t_phases

	// window change, demux and mux writes, mux read
	task automatic t_modes();
		int dc;
		int ds;
		int dl;
		logic [31:0] v;
		tim(2'd1, 4'h0, 2'd0, 5'd0, 1'b0, 2'd0, 2'd2, 1'b0);
		run(2'd1, 1'b1, 24'hA51234, 16'hBEEF, dc, ds, dl);
		check(32'(dc), 32'd4);
		check({w_adr, w_dat}, {24'hA51234, 16'hBEEF});
		check({31'h0, w_bhe_n}, 32'h0);
		run(2'd1, 1'b1, 24'h000001, 16'h0F0F, dc, ds, dl);
		check(32'(dc), 32'd2);
		tim(2'd2, 4'h8, 2'd1, 5'd2, 1'b1, 2'd1, 2'd3, 1'b1);
		run(2'd2, 1'b1, 24'h00C3A5, 16'h1357, dc, ds, dl);
		check(32'(dl), 32'd5);
		check({w_adr, w_dat}, {24'h00C3A5, 16'h1357});
		run(2'd2, 1'b0, 24'h00C3A5, 16'h0000, dc, ds, dl);
		check(32'(dc), 32'd8);
		bus_rd(REG_RDATA, v);
		check(v, {16'h0000, 16'hC3A5 ^ 16'h5A3C});
	endtask : t_modes

	// ready stretched access: sync, async, low active
	task automatic t_ready();
		int dc;
		int s1;
		int s2;
		int dl;
		rwait <= 4'd6;
		tim(2'd3, 4'h5, 2'd0, 5'd0, 1'b0, 2'd0, 2'd0, 1'b0);
		run(2'd3, 1'b0, 24'h000010, 16'h0000, dc, s1, dl);
		check(32'(s1 >= 7 && s1 <= 12), 32'd1);
		tim(2'd3, 4'h7, 2'd0, 5'd0, 1'b0, 2'd0, 2'd0, 1'b0);
		run(2'd3, 1'b1, 24'h000020, 16'h4444, dc, s2, dl);
		check(32'(s2 >= s1 + 1), 32'd1);
		rpol <= 1'b0;
		tim(2'd3, 4'h1, 2'd0, 5'd0, 1'b0, 2'd0, 2'd0, 1'b0);
		run(2'd3, 1'b0, 24'h000030, 16'h0000, dc, s2, dl);
		check(32'(s2), 32'(s1));
	endtask : t_ready

	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_phases();
		t_modes();
		t_ready();
		stop_test();
	end
endmodule : ebc_seq_test
`default_nettype wire
